// >>> lsp_pkg.sv
package lsp_pkg;

  // register byte offsets
  localparam logic [7:0] LSP_CTRL_OFF    = 8'h00;
  localparam logic [7:0] LSP_LOCK_OFF    = 8'h04;
  localparam logic [7:0] LSP_SRC_OFF     = 8'h08;
  localparam logic [7:0] LSP_STAT_OFF    = 8'h0C;
  localparam logic [7:0] LSP_CH_BASE     = 8'h10;
  localparam logic [7:0] LSP_CH_STRIDE   = 8'h10;
  localparam logic [7:0] LSP_RATE_OFF    = 8'h00;
  localparam logic [7:0] LSP_ONT_OFF     = 8'h04;
  localparam logic [7:0] LSP_FMT_OFF     = 8'h08;

  // ctrl field: bits 3:0 channel enables
  localparam int LSP_EN_LSB   = 0;
  // lock fields
  localparam int LSP_LOCKA_BIT = 0;
  localparam int LSP_LOCKB_BIT = 1;
  // source fields
  localparam int LSP_SRC1_LSB = 0;
  localparam int LSP_SRC3_LSB = 2;
  // format fields
  localparam int LSP_RFMT_BIT = 0;
  localparam int LSP_OFMT_BIT = 1;
  // status fields
  localparam int LSP_OUT_LSB  = 0;
  localparam int LSP_LOCKSTAT_LSB = 4;

  // reset values
  localparam logic [31:0] LSP_RATE_RST = 32'h0000_0064;
  localparam logic [31:0] LSP_ONT_RST  = 32'h0000_0000;

  // timing: 40 MHz clock, 25 ns
  localparam int unsigned LSP_CLK_HZ  = 40000000;
  localparam int unsigned LSP_MS_CYC  = LSP_CLK_HZ / 1000;
  localparam int unsigned LSP_CW      = 32;

  // parameter source select
  typedef enum logic [1:0] {
    LSP_SRC_HOST  = 2'b00,
    LSP_SRC_INLET = 2'b01,
    LSP_SRC_BLEED = 2'b10
  } lsp_src_t;

  // per-channel resolved parameters: period and on-time in clock cycles
  typedef struct packed {
    logic [31:0] period;
    logic [31:0] on_cyc;
  } lsp_param_t;

endpackage : lsp_pkg

// >>> lsp_ch_if.sv
interface lsp_ch_if;
  import lsp_pkg::*;
  logic       enable;
  lsp_param_t prm;
  logic       sync_restart;
  logic       pwm_out;
  logic       boundary;
  modport ctrl (output enable, output prm, output sync_restart, input pwm_out, input boundary);
  modport gen  (input enable, input prm, input sync_restart, output pwm_out, output boundary);
endinterface : lsp_ch_if

// >>> lsp_pwm_gen.sv
module lsp_pwm_gen
  import lsp_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // channel control
  lsp_ch_if.gen     ch
);

  logic [31:0] cnt_r;
  logic [31:0] per_r;
  logic [31:0] on_r;
  logic        out_r;
  logic        bnd_r;
  logic        run_r;
  logic        wrap;

  assign wrap = (cnt_r + 32'h0000_0001 >= per_r);

  // counter restarts on enable rise so locked pairs start on the same edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= 32'h0000_0000;
      per_r <= 32'h0000_0001;
      on_r  <= 32'h0000_0000;
      run_r <= 1'b0;
      bnd_r <= 1'b0;
    end
    else if (!ch.enable || ch.sync_restart)
    begin
      cnt_r <= 32'h0000_0000;
      run_r <= 1'b0;
      bnd_r <= 1'b0;
    end
    else if (!run_r || wrap)
    begin
      // new values only latched at a period boundary, so no cut pulse
      cnt_r <= 32'h0000_0000;                                           // [R16]
      per_r <= (ch.prm.period == 32'h0000_0000) ? 32'h0000_0001 : ch.prm.period;
      on_r  <= ch.prm.on_cyc;
      run_r <= 1'b1;
      bnd_r <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 32'h0000_0001;
      bnd_r <= 1'b0;
    end
  end

  // active for on-time, inactive for rest; disabled channel stays low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_r <= 1'b0;
    else if (!ch.enable || ch.sync_restart)
      out_r <= 1'b0;                                                    // [R1]
    else if (!run_r || wrap)
      out_r <= (ch.prm.on_cyc != 32'h0000_0000);                        // [R15]
    else
      out_r <= (cnt_r + 32'h0000_0001 < on_r);                          // [R15]
  end

  assign ch.pwm_out  = out_r;
  assign ch.boundary = bnd_r;

endmodule : lsp_pwm_gen

// >>> lsp_lowside_pwm.sv
// Notes on behaviour
// (R1) enabled channel runs PWM, disabled stays idle
// (R2) pair A lock: channel one drives both
// (R3) pair B lock: channel three drives both
// (R4) locked pair switches with aligned edges
// (R5) pair A lock changes only when both disabled
// (R6) pair B lock changes only when both disabled
// (R7) pair A locked: channel two settings ignored
// (R8) pair B locked: channel four settings ignored
// (R9) channel one source: host, inlet, bleed
// (R10) channel three source: host, inlet, bleed
// (R11) rate from frequency or period select
// (R12) on-time from duty or pulse width
// (R13) caller should lock pair A for valves
// (R14) caller should lock pair B for valves
// (R15) output active for on-time each period
// (R16) new values apply at period boundary
module lsp_lowside_pwm
  import lsp_pkg::*;
(
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // pressure-control function parameters (same clock), host-format values
  input  wire logic [31:0] inlet_rate_hz,
  input  wire logic [31:0] inlet_duty_percent,
  input  wire logic [31:0] bleed_rate_hz,
  input  wire logic [31:0] bleed_duty_percent,
  // lowside outputs
  output logic      [3:0]  lowside_output
);

  localparam int NCH = 4;

  // host registers
  logic [3:0]  lowside_channel_enable_r;
  logic        pair_a_lock_r;
  logic        pair_b_lock_r;
  lsp_src_t    chan_one_param_source_r;
  lsp_src_t    chan_three_param_source_r;
  logic [31:0] rate_r     [NCH];   // pwm_rate_hz or pwm_cycle_ms
  logic [31:0] ont_r      [NCH];   // pwm_duty_percent or pwm_on_time_ms
  logic [NCH-1:0] rate_format_select_r;   // 1 = period in ms
  logic [NCH-1:0] on_time_format_select_r; // 1 = pulse width in ms
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [3:0]  lowside_output_r;
  logic [3:0]  en_d_r;

  lsp_ch_if chif [NCH] ();
  lsp_param_t own_prm [NCH];

  // turns a host setting into cycle counts
  function automatic lsp_param_t lsp_convert(input logic [31:0] rate, input logic [31:0] ont,
                                             input logic rfmt, input logic ofmt);
    lsp_param_t  p;
    logic [63:0] per64;
    logic [63:0] on64;
    per64 = 64'h0000_0000_0000_0000;
    on64  = 64'h0000_0000_0000_0000;
    if (rfmt)
      per64 = 64'(rate) * 64'(LSP_MS_CYC);                              // [R11]
    else if (rate != 32'h0000_0000)
      per64 = 64'(LSP_CLK_HZ) / 64'(rate);                              // [R11]
    if (ofmt)
      on64 = 64'(ont) * 64'(LSP_MS_CYC);                                // [R12]
    else
      on64 = (per64 * 64'(ont)) / 64'd100;                              // [R12]
    p.period = (per64 > 64'h0000_0000_FFFF_FFFF) ? 32'hFFFF_FFFF : per64[31:0];
    p.on_cyc = (on64 > per64) ? p.period : on64[31:0];
    return p;
  endfunction : lsp_convert

  // register index decode, used by both write and read paths
  function automatic int lsp_chan_of(input logic [7:0] a);
    return int'((a - LSP_CH_BASE) >> 4);
  endfunction : lsp_chan_of

  function automatic logic lsp_is_chan(input logic [7:0] a);
    return (a >= LSP_CH_BASE) && (a < LSP_CH_BASE + 8'(NCH) * LSP_CH_STRIDE)
           && (a[3:0] <= LSP_FMT_OFF[3:0]) && (a[1:0] == 2'b00);
  endfunction : lsp_is_chan

  logic acc;
  logic wr;
  logic mapped;
  assign acc    = psel && penable;
  assign wr     = acc && pwrite;
  assign mapped = (paddr == LSP_CTRL_OFF) || (paddr == LSP_LOCK_OFF) || (paddr == LSP_SRC_OFF)
                  || (paddr == LSP_STAT_OFF) || lsp_is_chan(paddr);

  // global control writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lowside_channel_enable_r  <= 4'h0;
      chan_one_param_source_r   <= LSP_SRC_HOST;
      chan_three_param_source_r <= LSP_SRC_HOST;
    end
    else if (wr)
    begin
      if (paddr == LSP_CTRL_OFF)
        lowside_channel_enable_r <= pwdata[LSP_EN_LSB +: 4];            // [R1]
      if (paddr == LSP_SRC_OFF)
      begin
        // reserved code 3 falls back to host so the channel never lacks a source
        chan_one_param_source_r   <= (pwdata[LSP_SRC1_LSB +: 2] == 2'b11) ? LSP_SRC_HOST
                                     : lsp_src_t'(pwdata[LSP_SRC1_LSB +: 2]);  // [R9]
        chan_three_param_source_r <= (pwdata[LSP_SRC3_LSB +: 2] == 2'b11) ? LSP_SRC_HOST
                                     : lsp_src_t'(pwdata[LSP_SRC3_LSB +: 2]);  // [R10]
      end
    end
  end

  // lock bits: a write is dropped unless both channels of the pair are off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pair_a_lock_r <= 1'b0;
      pair_b_lock_r <= 1'b0;
    end
    else if (wr && paddr == LSP_LOCK_OFF)
    begin
      if (lowside_channel_enable_r[1:0] == 2'b00)
        pair_a_lock_r <= pwdata[LSP_LOCKA_BIT];                         // [R5]
      if (lowside_channel_enable_r[3:2] == 2'b00)
        pair_b_lock_r <= pwdata[LSP_LOCKB_BIT];                         // [R6]
    end
  end

  // per-channel parameter registers
  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          rate_r[g]                  <= LSP_RATE_RST;
          ont_r[g]                   <= LSP_ONT_RST;
          rate_format_select_r[g]    <= 1'b0;
          on_time_format_select_r[g] <= 1'b0;
        end
        else if (wr && lsp_is_chan(paddr) && lsp_chan_of(paddr) == g)
        begin
          if (paddr[3:0] == LSP_RATE_OFF[3:0])
            rate_r[g] <= pwdata;
          if (paddr[3:0] == LSP_ONT_OFF[3:0])
            ont_r[g] <= pwdata;
          if (paddr[3:0] == LSP_FMT_OFF[3:0])
          begin
            rate_format_select_r[g]    <= pwdata[LSP_RFMT_BIT];
            on_time_format_select_r[g] <= pwdata[LSP_OFMT_BIT];
          end
        end
      end
      assign own_prm[g] = lsp_convert(rate_r[g], ont_r[g], rate_format_select_r[g],
                                      on_time_format_select_r[g]);
    end
  endgenerate

  // source selection for channels one and three; the control functions use hz and percent
  lsp_param_t src1_prm;
  lsp_param_t src3_prm;
  always_comb
  begin
    case (chan_one_param_source_r)
      LSP_SRC_INLET: src1_prm = lsp_convert(inlet_rate_hz, inlet_duty_percent, 1'b0, 1'b0); // [R9]
      LSP_SRC_BLEED: src1_prm = lsp_convert(bleed_rate_hz, bleed_duty_percent, 1'b0, 1'b0); // [R9]
      default:       src1_prm = own_prm[0];
    endcase
    case (chan_three_param_source_r)
      LSP_SRC_INLET: src3_prm = lsp_convert(inlet_rate_hz, inlet_duty_percent, 1'b0, 1'b0); // [R10]
      LSP_SRC_BLEED: src3_prm = lsp_convert(bleed_rate_hz, bleed_duty_percent, 1'b0, 1'b0); // [R10]
      default:       src3_prm = own_prm[2];
    endcase
  end

  // enable-rise restarts both generators of a locked pair together
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      en_d_r <= 4'h0;
    else
      en_d_r <= lowside_channel_enable_r;
  end

  // locked pair: upper channel gets lower channel's parameters and enable
  assign chif[0].enable = lowside_channel_enable_r[0];
  assign chif[0].prm    = src1_prm;
  assign chif[0].sync_restart = pair_a_lock_r && lowside_channel_enable_r[0]
                                && !en_d_r[0];                          // [R4]
  assign chif[1].enable = pair_a_lock_r ? lowside_channel_enable_r[0] : lowside_channel_enable_r[1];
  assign chif[1].prm    = pair_a_lock_r ? src1_prm : own_prm[1];        // [R2] [R7]
  assign chif[1].sync_restart = chif[0].sync_restart;                   // [R4]
  assign chif[2].enable = lowside_channel_enable_r[2];
  assign chif[2].prm    = src3_prm;
  assign chif[2].sync_restart = pair_b_lock_r && lowside_channel_enable_r[2]
                                && !en_d_r[2];                          // [R4]
  assign chif[3].enable = pair_b_lock_r ? lowside_channel_enable_r[2] : lowside_channel_enable_r[3];
  assign chif[3].prm    = pair_b_lock_r ? src3_prm : own_prm[3];        // [R3] [R8]
  assign chif[3].sync_restart = chif[2].sync_restart;                   // [R4]

  generate
    for (g = 0; g < NCH; g++)
    begin : g_gen
      lsp_pwm_gen u_gen
      (
        .pclk    (pclk),
        .presetn (presetn),
        .ch      (chif[g].gen)
      );
    end
  endgenerate

  logic [3:0] gen_out;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_out
      assign gen_out[g] = chif[g].pwm_out;
    end
  endgenerate

  // outputs re-registered; locked pair members share one timing so edges stay aligned
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lowside_output_r <= 4'h0;
    else
      lowside_output_r <= gen_out;                                       // [R4]
  end

  // read mux and answer; no wait states, so pready always comes in the first access cycle
  logic [31:0] rd_val;
  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (paddr == LSP_CTRL_OFF)
      rd_val[LSP_EN_LSB +: 4] = lowside_channel_enable_r;
    else if (paddr == LSP_LOCK_OFF)
    begin
      rd_val[LSP_LOCKA_BIT] = pair_a_lock_r;
      rd_val[LSP_LOCKB_BIT] = pair_b_lock_r;
    end
    else if (paddr == LSP_SRC_OFF)
    begin
      rd_val[LSP_SRC1_LSB +: 2] = chan_one_param_source_r;
      rd_val[LSP_SRC3_LSB +: 2] = chan_three_param_source_r;
    end
    else if (paddr == LSP_STAT_OFF)
    begin
      rd_val[LSP_OUT_LSB +: 4] = lowside_output_r;
      rd_val[LSP_LOCKSTAT_LSB +: 4] = {chif[3].enable, chif[2].enable, chif[1].enable, chif[0].enable};
    end
    else if (lsp_is_chan(paddr))
    begin
      for (int i = 0; i < NCH; i++)
        if (lsp_chan_of(paddr) == i)
        begin
          if (paddr[3:0] == LSP_RATE_OFF[3:0])
            rd_val = rate_r[i];
          else if (paddr[3:0] == LSP_ONT_OFF[3:0])
            rd_val = ont_r[i];
          else
            rd_val = {30'h0000_0000, on_time_format_select_r[i], rate_format_select_r[i]};
        end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r  <= psel && !penable;
      pslverr_r <= psel && !penable && !mapped;
      prdata_r  <= (psel && !penable && !pwrite) ? rd_val : 32'h0000_0000;
    end
  end

  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = pslverr_r;
  assign lowside_output = lowside_output_r;

endmodule : lsp_lowside_pwm

// >>> lsp_pwm_checker.sv
module lsp_pwm_checker
  import lsp_pkg::*;
(
  // apb side
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // outputs
  input  wire logic [3:0]  lowside_output
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] en_r;
  logic [1:0] lock_r;
  wire        wr_acc = psel && penable && pready && pwrite;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // shadow of the enable register, written at the access edge
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) en_r <= '0;
    else if (wr_acc && paddr == LSP_CTRL_OFF) en_r <= pwdata[3:0];

  // a pair lock only moves while both its enables are clear
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) lock_r <= '0;
    else if (wr_acc && paddr == LSP_LOCK_OFF)
    begin
      if (en_r[1:0] == 2'h0) lock_r[0] <= pwdata[0];
      if (en_r[3:2] == 2'h0) lock_r[1] <= pwdata[1];
    end

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_read(logic [7:0] a);
    s_setup ##0 (!pwrite && paddr == a);
  endsequence

  property p_ready_after_setup;
    s_setup |=> pready;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
  property p_rdata_idle;
    !pready |-> prdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside access");
  property p_unmapped_err;
    s_setup ##0 (paddr >= 8'h50) |=> pslverr;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not refused");
  property p_lock_readback;
    s_read(LSP_LOCK_OFF) |=> prdata[1:0] == lock_r;
  endproperty
  a_lock_readback: assert property (p_lock_readback) else $error("lock value wrong");
  property p_ctrl_readback;
    s_read(LSP_CTRL_OFF) |=> prdata[3:0] == en_r;
  endproperty
  a_ctrl_readback: assert property (p_ctrl_readback) else $error("enable value wrong");
  property p_off_when_disabled;
    !en_r[0] [*4] |-> !lowside_output[0];
  endproperty
  a_off_when_disabled: assert property (p_off_when_disabled) else $error("disabled channel active");
  property p_sync_a;
    lock_r[0] && en_r[0] |-> lowside_output[0] == lowside_output[1];
  endproperty
  a_sync_a: assert property (p_sync_a) else $error("pair a edges apart");
  property p_sync_b;
    lock_r[1] && en_r[2] |-> lowside_output[2] == lowside_output[3];
  endproperty
  a_sync_b: assert property (p_sync_b) else $error("pair b edges apart");
endmodule : lsp_pwm_checker

bind lsp_lowside_pwm lsp_pwm_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .lowside_output(lowside_output));

// >>> lsp_load_model.sv
module lsp_load_model
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // switch drive seen by the valve coils
  input  wire logic [3:0]  lowside_output,
  // measured figures per channel
  output int unsigned      high_cyc [4],
  output int unsigned      per_cyc [4],
  output int unsigned      rises [4]
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0]  prev_r;
  int unsigned cnt_r [4];

  // a coil only sees on and off, so timing edges is all the load needs
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      prev_r <= '0;
      for (int i = 0; i < 4; i++)
      begin
        cnt_r[i] <= 0;
        rises[i] <= 0;
        per_cyc[i] <= 0;
        high_cyc[i] <= 0;
      end
    end
    else
    begin
      prev_r <= lowside_output;
      for (int i = 0; i < 4; i++)
      begin
        if (lowside_output[i] && !prev_r[i])
        begin
          per_cyc[i] <= cnt_r[i];
          cnt_r[i] <= 1;
          rises[i] <= rises[i] + 1;
        end
        else cnt_r[i] <= cnt_r[i] + 1;
        if (!lowside_output[i] && prev_r[i]) high_cyc[i] <= cnt_r[i];
      end
    end
endmodule : lsp_load_model

// >>> test_lowside_pwm_channels.sv
module test_lowside_pwm_channels
  import lsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, err_q;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_q, ihz, idu, bhz, bdu, hz0, d0, hz2, d2;
  logic [3:0]  lowside_output;
  int unsigned high_cyc [4], per_cyc [4], rises [4], base [4];
  int          failures, cmp_count;

  lsp_lowside_pwm DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .inlet_rate_hz(ihz), .inlet_duty_percent(idu), .bleed_rate_hz(bhz), .bleed_duty_percent(bdu),
    .lowside_output(lowside_output));
  lsp_load_model u_load (.pclk(pclk), .presetn(presetn), .lowside_output(lowside_output),
    .high_cyc(high_cyc), .per_cyc(per_cyc), .rises(rises));

  always #12.5 pclk = ~pclk;

  function automatic logic [31:0] exp_per(input logic [31:0] hz);
    return LSP_CLK_HZ / hz;
  endfunction : exp_per

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  // one apb transfer; holds the request until ready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      failures++;
      finish_test();
    end
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // skip the boundary that may already be under way before snapshotting
  task automatic snap();
    repeat (3) @(posedge pclk);
    base = rises;
  endtask : snap

  // two rises after the snapshot give one whole period with fresh values
  task automatic meas(input int ch, input logic [31:0] per, input logic [31:0] duty);
    int n;
    n = 0;
    while (rises[ch] < base[ch] + 2 && n < 60000)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 60000)
    begin
      failures++;
      finish_test();
    end
    check("period", per_cyc[ch], per);
    check("on time", high_cyc[ch], per * duty / 100);
  endtask : meas

  initial
  begin
    void'($urandom(32'h3316_f712));
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {ihz, idu, bhz, bdu} = {4{32'h0000_0064}};
    failures = 0;
    cmp_count = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, LSP_CTRL_OFF, 0);
    check("enables", rd_q, 32'h0000_0000);
    apb(1'b0, LSP_CH_BASE, 0);
    check("rate reset", rd_q, LSP_RATE_RST);
    apb(1'b0, 8'h80, 0);
    check("unmapped error", {31'h0, err_q}, 32'h0000_0001);
    // host values: ch one in hertz and percent, ch two period in milliseconds and duty in percent
    hz0 = 20000 + $urandom % 60000;
    d0 = 10 + $urandom % 81;
    hz2 = 20000 + $urandom % 60000;
    d2 = 10 + $urandom % 81;
    apb(1'b1, 8'h10, hz0);
    apb(1'b1, 8'h14, d0);
    apb(1'b1, 8'h20, 32'h0000_0001);
    apb(1'b1, 8'h24, 32'h0000_0032);
    apb(1'b1, 8'h28, 32'h0000_0001);
    base = rises;
    apb(1'b1, LSP_CTRL_OFF, 32'h0000_0003);
    meas(0, exp_per(hz0), d0);
    meas(1, LSP_MS_CYC, 50);
    check("idle channel", rises[3], 0);
    // pair a is running so only pair b may lock
    apb(1'b1, LSP_LOCK_OFF, 32'h0000_0003);
    apb(1'b0, LSP_LOCK_OFF, 0);
    check("lock refused", rd_q, 32'h0000_0002);
    apb(1'b1, LSP_CTRL_OFF, 32'h0000_0000);
    repeat (50) @(posedge pclk);
    apb(1'b1, LSP_LOCK_OFF, 32'h0000_0003);
    apb(1'b0, LSP_LOCK_OFF, 0);
    check("lock taken", rd_q, 32'h0000_0003);
    // upper channel values that must be ignored while locked, then channel three's own host values
    apb(1'b1, 8'h20, 25000);
    apb(1'b1, 8'h24, 32'h0000_0050);
    apb(1'b1, 8'h28, 32'h0000_0000);
    apb(1'b1, 8'h40, 30000);
    apb(1'b1, 8'h44, 32'h0000_0046);
    apb(1'b1, 8'h30, hz2);
    apb(1'b1, 8'h34, d2);
    ihz <= 20000 + $urandom % 60000;
    idu <= 10 + $urandom % 81;
    bhz <= 20000 + $urandom % 60000;
    bdu <= 10 + $urandom % 81;
    // valve sources run with their pairs locked
    apb(1'b1, LSP_SRC_OFF, 32'h0000_0009);
    base = rises;
    // upper enable bits set as well: a locked upper channel must ignore its own enable
    apb(1'b1, LSP_CTRL_OFF, 32'h0000_000F);
    meas(1, exp_per(ihz), idu);
    meas(3, exp_per(bhz), bdu);
    // swap the sources in mid-run
    apb(1'b1, LSP_SRC_OFF, 32'h0000_0006);
    snap();
    meas(0, exp_per(bhz), bdu);
    meas(2, exp_per(ihz), idu);
    apb(1'b1, LSP_SRC_OFF, 32'h0000_0000);
    snap();
    meas(2, exp_per(hz2), d2);
    finish_test();
  end
endmodule : test_lowside_pwm_channels
